//--- hdl/cbs_pkg.sv
/*
  Package for the conditional branch and skip unit: operation codes, flag
  positions, widths, reset values and cycle counts.
  Assumes a decoder upstream that presents one operation at a time.
*/
package cbs_pkg;

  localparam int PC_W        = 16;
  localparam int OFFS_W      = 7;

  // Operation select presented by the decoder
  typedef enum logic [3:0] {
    CBS_OP_NONE     = 4'h0,
    CBS_OP_SKIP_IO  = 4'h1,
    CBS_OP_BR_SET   = 4'h2,
    CBS_OP_BR_CLR   = 4'h3,
    CBS_OP_BR_EQ    = 4'h4,
    CBS_OP_BR_NE    = 4'h5,
    CBS_OP_BR_CS    = 4'h6,
    CBS_OP_BR_CC    = 4'h7,
    CBS_OP_BR_SH    = 4'h8,
    CBS_OP_BR_LO    = 4'h9
  } cbs_op_t;

  // Status register bit positions
  localparam logic [2:0] FLAG_C_POS = 3'h0;
  localparam logic [2:0] FLAG_Z_POS = 3'h1;

  // Skip distances and reset values
  localparam logic [PC_W-1:0] SKIP_ONE_WORD = 16'h0002;
  localparam logic [PC_W-1:0] SKIP_TWO_WORD = 16'h0003;
  localparam logic [PC_W-1:0] PC_STEP       = 16'h0001;
  localparam logic [PC_W-1:0] PC_RESET      = 16'h0000;
  localparam logic [7:0]      STATUS_RESET  = 8'h00;

  // Cycle counts: not taken / taken branch, skip of one or two words
  localparam logic [1:0] CYC_NOT_TAKEN = 2'h1;
  localparam logic [1:0] CYC_TAKEN     = 2'h2;
  localparam logic [1:0] CYC_SKIP_TWO  = 2'h3;

endpackage

//--- hdl/cbs_status_reg.sv
/*
  Status register holder for the branch unit. Loads only on an explicit write
  from the arithmetic side; branch and skip operations never write it.
  Assumes writer logic on the same clock.
*/
`timescale 1ns/10ps
module cbs_status_reg (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] status_ff
);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_ff <= cbs_pkg::STATUS_RESET;
    end else if (wr_en) begin
      status_ff <= wr_data;
    end
  end

endmodule

//--- hdl/cbs_branch_unit.sv
/*
  Conditional branch and skip unit: evaluates skip-on-I/O-bit and relative
  branches on status bits, updates the program counter and stalls the fetch
  for the extra cycles the operation takes.
  Assumes a decoder on ref_clk that holds op and operands while op_ready is
  low, and an I/O bus that returns the addressed register the same cycle.
*/
`timescale 1ns/10ps
// Operation
// - Skip on set I/O bit advances pc by 2 or 3, 1/2/3 cycles
// - Branch on status bit set loads pc+k+1, 1 or 2 cycles
// - Branch on status bit clear loads pc+k+1, else sequential
// - Branch if equal adds k+1 when zero flag is one
// - Branch if not equal adds k+1 when zero flag is zero
// - Carry set and lower branches add k+1 when carry is one
// - Carry clear and same-or-higher branches add k+1 when carry zero
module cbs_branch_unit (
  input  wire logic                         ref_clk,
  input  wire logic                         rst_n,
  input  wire logic                         op_valid,
  input  wire cbs_pkg::cbs_op_t             op,
  input  wire logic [2:0]                   bit_sel,
  input  wire logic [cbs_pkg::OFFS_W-1:0]   offset_k,
  input  wire logic [7:0]                   io_data,
  input  wire logic                         next_is_two_word,
  input  wire logic                         flag_wr_en,
  input  wire logic [7:0]                   flag_wr_data,
  output logic                              op_ready,
  output logic [cbs_pkg::PC_W-1:0]          pc,
  output logic [7:0]                        status_register,
  output logic                              taken
);

  typedef enum logic [1:0] {
    CBS_IDLE = 2'b00,
    CBS_WAIT = 2'b01
  } cbs_state_t;

  cbs_state_t                 state_ff;
  logic [1:0]                 wait_ff;
  logic [cbs_pkg::PC_W-1:0]   pc_ff;
  logic                       taken_ff;
  logic                       cond;
  logic [cbs_pkg::PC_W-1:0]   nxt_pc;
  logic [1:0]                 nxt_cycles;
  logic                       accept;

  // Sign-extend a 7-bit word offset to the pc width
  function automatic logic [cbs_pkg::PC_W-1:0] sext_k(input logic [cbs_pkg::OFFS_W-1:0] k);
    sext_k = {{(cbs_pkg::PC_W-cbs_pkg::OFFS_W){k[cbs_pkg::OFFS_W-1]}}, k};
  endfunction

  // Flag writes come only from the arithmetic side, never from this unit
  cbs_status_reg u_status (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .wr_en     (flag_wr_en),
    .wr_data   (flag_wr_data),
    .status_ff (status_register)
  );

  always_comb begin
    case (op)
      cbs_pkg::CBS_OP_SKIP_IO: cond = io_data[bit_sel];
      cbs_pkg::CBS_OP_BR_SET:  cond = status_register[bit_sel];
      cbs_pkg::CBS_OP_BR_CLR:  cond = ~status_register[bit_sel];
      cbs_pkg::CBS_OP_BR_EQ:   cond = status_register[cbs_pkg::FLAG_Z_POS];
      cbs_pkg::CBS_OP_BR_NE:   cond = ~status_register[cbs_pkg::FLAG_Z_POS];
      cbs_pkg::CBS_OP_BR_CS,
      cbs_pkg::CBS_OP_BR_LO:   cond = status_register[cbs_pkg::FLAG_C_POS];
      cbs_pkg::CBS_OP_BR_CC,
      cbs_pkg::CBS_OP_BR_SH:   cond = ~status_register[cbs_pkg::FLAG_C_POS];
      default:                 cond = 1'b0;
    endcase
  end

  always_comb begin
    nxt_pc     = pc_ff + cbs_pkg::PC_STEP;
    nxt_cycles = cbs_pkg::CYC_NOT_TAKEN;
    if (cond && op == cbs_pkg::CBS_OP_SKIP_IO) begin
      // Skipping a two-word instruction needs one more fetch cycle
      nxt_pc     = pc_ff + (next_is_two_word ? cbs_pkg::SKIP_TWO_WORD : cbs_pkg::SKIP_ONE_WORD);
      nxt_cycles = next_is_two_word ? cbs_pkg::CYC_SKIP_TWO : cbs_pkg::CYC_TAKEN;
    end else if (cond) begin
      nxt_pc     = pc_ff + sext_k(offset_k) + cbs_pkg::PC_STEP;
      nxt_cycles = cbs_pkg::CYC_TAKEN;
    end
  end

  assign op_ready = (state_ff == CBS_IDLE);
  assign accept   = op_valid && op_ready;
  assign pc       = pc_ff;
  assign taken    = taken_ff;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_ff    <= cbs_pkg::PC_RESET;
      taken_ff <= 1'b0;
    end else if (accept) begin
      pc_ff    <= nxt_pc;
      taken_ff <= cond;
    end
  end

  // Extra cycles of a taken branch or skip hold off the next operation
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= CBS_IDLE;
      wait_ff  <= 2'h0;
    end else begin
      case (state_ff)
        CBS_IDLE: begin
          if (accept && nxt_cycles != cbs_pkg::CYC_NOT_TAKEN) begin
            state_ff <= CBS_WAIT;
            wait_ff  <= nxt_cycles - cbs_pkg::CYC_NOT_TAKEN;
          end
        end
        CBS_WAIT: begin
          wait_ff <= wait_ff - 2'h1;
          if (wait_ff == 2'h1) begin
            state_ff <= CBS_IDLE;
          end
        end
        default: state_ff <= CBS_IDLE;
      endcase
    end
  end

  // Assertions
  property p_skip_pc;
    @(posedge ref_clk) disable iff (!rst_n)
    accept && op == cbs_pkg::CBS_OP_SKIP_IO && io_data[bit_sel] |=>
      pc == $past(pc_ff) + ($past(next_is_two_word) ? cbs_pkg::SKIP_TWO_WORD : cbs_pkg::SKIP_ONE_WORD);
  endproperty
  a_skip_pc: assert property (p_skip_pc) else $error("skip pc wrong");

  property p_skip_two_cycles;
    @(posedge ref_clk) disable iff (!rst_n)
    accept && op == cbs_pkg::CBS_OP_SKIP_IO && io_data[bit_sel] && next_is_two_word |=>
      !op_ready [*2] ##1 op_ready;
  endproperty
  a_skip_two_cycles: assert property (p_skip_two_cycles) else $error("skip cycles wrong");

  property p_br_set;
    @(posedge ref_clk) disable iff (!rst_n)
    accept && op == cbs_pkg::CBS_OP_BR_SET |=>
      pc == ($past(status_register[bit_sel]) ? $past(pc_ff) + sext_k($past(offset_k)) + cbs_pkg::PC_STEP
                                             : $past(pc_ff) + cbs_pkg::PC_STEP);
  endproperty
  a_br_set: assert property (p_br_set) else $error("set branch pc wrong");

  property p_br_clr;
    @(posedge ref_clk) disable iff (!rst_n)
    accept && op == cbs_pkg::CBS_OP_BR_CLR && status_register[bit_sel] |=>
      pc == $past(pc_ff) + cbs_pkg::PC_STEP;
  endproperty
  a_br_clr: assert property (p_br_clr) else $error("clear branch not sequential");

  property p_br_eq;
    @(posedge ref_clk) disable iff (!rst_n)
    accept && op == cbs_pkg::CBS_OP_BR_EQ |=> taken == $past(status_register[cbs_pkg::FLAG_Z_POS]);
  endproperty
  a_br_eq: assert property (p_br_eq) else $error("equal branch decision wrong");

  property p_br_ne;
    @(posedge ref_clk) disable iff (!rst_n)
    accept && op == cbs_pkg::CBS_OP_BR_NE && !status_register[cbs_pkg::FLAG_Z_POS] |=> !op_ready ##1 op_ready;
  endproperty
  a_br_ne: assert property (p_br_ne) else $error("not equal branch timing wrong");

  property p_br_carry;
    @(posedge ref_clk) disable iff (!rst_n)
    accept && (op == cbs_pkg::CBS_OP_BR_CS || op == cbs_pkg::CBS_OP_BR_LO) |=>
      taken == $past(status_register[cbs_pkg::FLAG_C_POS]);
  endproperty
  a_br_carry: assert property (p_br_carry) else $error("carry set branch wrong");

  property p_br_nocarry;
    @(posedge ref_clk) disable iff (!rst_n)
    accept && (op == cbs_pkg::CBS_OP_BR_CC || op == cbs_pkg::CBS_OP_BR_SH) |=>
      taken != $past(status_register[cbs_pkg::FLAG_C_POS]);
  endproperty
  a_br_nocarry: assert property (p_br_nocarry) else $error("carry clear branch wrong");

  property p_flags_kept;
    @(posedge ref_clk) disable iff (!rst_n)
    accept && !flag_wr_en |=> $stable(status_register);
  endproperty
  a_flags_kept: assert property (p_flags_kept) else $error("branch changed flags");

  // Target checks per flag: the decision checks above say nothing about the offset arithmetic
  property p_br_eq_pc;
    @(posedge ref_clk) disable iff (!rst_n)
    accept && op == cbs_pkg::CBS_OP_BR_EQ && status_register[cbs_pkg::FLAG_Z_POS] |=>
      pc == $past(pc_ff) + sext_k($past(offset_k)) + cbs_pkg::PC_STEP;
  endproperty
  a_br_eq_pc: assert property (p_br_eq_pc) else $error("equal branch target wrong");

  property p_br_ne_pc;
    @(posedge ref_clk) disable iff (!rst_n)
    accept && op == cbs_pkg::CBS_OP_BR_NE && !status_register[cbs_pkg::FLAG_Z_POS] |=>
      pc == $past(pc_ff) + sext_k($past(offset_k)) + cbs_pkg::PC_STEP;
  endproperty
  a_br_ne_pc: assert property (p_br_ne_pc) else $error("not equal branch target wrong");

  property p_br_carry_pc;
    @(posedge ref_clk) disable iff (!rst_n)
    accept && (op == cbs_pkg::CBS_OP_BR_CS || op == cbs_pkg::CBS_OP_BR_LO) && status_register[cbs_pkg::FLAG_C_POS] |=>
      pc == $past(pc_ff) + sext_k($past(offset_k)) + cbs_pkg::PC_STEP;
  endproperty
  a_br_carry_pc: assert property (p_br_carry_pc) else $error("carry set branch target wrong");

  property p_br_nocarry_pc;
    @(posedge ref_clk) disable iff (!rst_n)
    accept && (op == cbs_pkg::CBS_OP_BR_CC || op == cbs_pkg::CBS_OP_BR_SH) &&
      !status_register[cbs_pkg::FLAG_C_POS] |=>
      pc == $past(pc_ff) + sext_k($past(offset_k)) + cbs_pkg::PC_STEP;
  endproperty
  a_br_nocarry_pc: assert property (p_br_nocarry_pc) else $error("carry clear branch target wrong");

  // A failed condition costs one cycle, so back-to-back issue must stay possible
  property p_not_taken_seq;
    @(posedge ref_clk) disable iff (!rst_n)
    accept && !cond |=> op_ready && !taken && pc == $past(pc_ff) + cbs_pkg::PC_STEP;
  endproperty
  a_not_taken_seq: assert property (p_not_taken_seq) else $error("untaken operation not sequential");

  c_skip_two: cover property (@(posedge ref_clk) disable iff (!rst_n)
    accept && op == cbs_pkg::CBS_OP_SKIP_IO && io_data[bit_sel] && next_is_two_word);
  c_br_taken: cover property (@(posedge ref_clk) disable iff (!rst_n) accept && cond && op != cbs_pkg::CBS_OP_SKIP_IO);
  c_br_not_taken: cover property (@(posedge ref_clk) disable iff (!rst_n) accept && !cond);
  c_skip_one: cover property (@(posedge ref_clk) disable iff (!rst_n)
    accept && op == cbs_pkg::CBS_OP_SKIP_IO && io_data[bit_sel] && !next_is_two_word);
  c_br_back: cover property (@(posedge ref_clk) disable iff (!rst_n)
    accept && cond && op != cbs_pkg::CBS_OP_SKIP_IO && offset_k[cbs_pkg::OFFS_W-1]);

endmodule

//--- testbench/conditional_branch_skip_unit_tb_top.sv
/*
  Self-checking bench for the conditional branch and skip unit.
  Assumes cbs_pkg is compiled first; all inputs change on the falling edge.
*/
`timescale 1ns/10ps
module conditional_branch_skip_unit_tb_top;
  logic                       ref_clk          = 1'b0;
  logic                       rst_n            = 1'b0;
  logic                       op_valid         = 1'b0;
  cbs_pkg::cbs_op_t           op               = cbs_pkg::CBS_OP_NONE;
  logic [2:0]                 bit_sel          = 3'h0;
  logic [cbs_pkg::OFFS_W-1:0] offset_k         = 7'h00;
  logic [7:0]                 io_data          = 8'h00;
  logic                       next_is_two_word = 1'b0;
  logic                       flag_wr_en       = 1'b0;
  logic [7:0]                 flag_wr_data     = 8'h00;
  logic                       op_ready;
  logic [cbs_pkg::PC_W-1:0]   pc;
  logic [7:0]                 status_register;
  logic                       taken;
  logic [cbs_pkg::PC_W-1:0]   exp_pc           = 16'h0000;
  logic [7:0]                 exp_st           = 8'h00;
  int                         failures         = 0;
  int                         n_tests          = 0;

  always #12.5 ref_clk = ~ref_clk;

  cbs_branch_unit u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .op_valid(op_valid), .op(op), .bit_sel(bit_sel),
    .offset_k(offset_k), .io_data(io_data), .next_is_two_word(next_is_two_word),
    .flag_wr_en(flag_wr_en), .flag_wr_data(flag_wr_data), .op_ready(op_ready), .pc(pc),
    .status_register(status_register), .taken(taken)
  );

  task automatic fail(input string msg);
    failures++;
    $display("ERROR at %0t: %s", $time, msg);
  endtask
  task automatic chk_pc(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) fail($sformatf("pc %h expected %h", got, exp));
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) fail($sformatf("flag %b expected %b", got, exp));
  endtask
  task automatic chk_st(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) fail($sformatf("status %h expected %h", got, exp));
  endtask
  task automatic chk_cyc(input int got, input int exp);
    n_tests++;
    if (got != exp) fail($sformatf("stall %0d expected %0d", got, exp));
  endtask

  task automatic conclude;
    $display("Checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Lowering op_valid here keeps a held operation from being taken twice
  task automatic set_flags(input logic [7:0] v);
    op_valid = 1'b0;
    flag_wr_en = 1'b1;
    flag_wr_data = v;
    @(negedge ref_clk);
    flag_wr_en = 1'b0;
    exp_st = v;
    chk_st(status_register, exp_st);
  endtask

  // Not-taken operations leave op_valid high so the next one follows back to back
  task automatic do_op(input cbs_pkg::cbs_op_t o, input logic [2:0] b, input logic [6:0] k,
                       input logic [7:0] io, input logic tw, input logic tk, input int cyc);
    int n = 0;
    op_valid = 1'b1;
    op = o;
    bit_sel = b;
    offset_k = k;
    io_data = io;
    next_is_two_word = tw;
    @(negedge ref_clk);
    if (cyc > 0) op_valid = 1'b0;
    exp_pc = exp_pc + (!tk ? cbs_pkg::PC_STEP : (o == cbs_pkg::CBS_OP_SKIP_IO) ?
             (tw ? cbs_pkg::SKIP_TWO_WORD : cbs_pkg::SKIP_ONE_WORD) : {{9{k[6]}}, k} + cbs_pkg::PC_STEP);
    chk_pc(pc, exp_pc);
    chk_bit(taken, tk);
    chk_st(status_register, exp_st);
    while (op_ready !== 1'b1 && n < 8) begin
      n++;
      @(negedge ref_clk);
    end
    if (n == 8) begin
      fail("op_ready never returned");
      conclude();
    end else begin
      chk_cyc(n, cyc);
    end
  endtask

  task automatic t_reset;
    chk_pc(pc, cbs_pkg::PC_RESET);
    chk_st(status_register, cbs_pkg::STATUS_RESET);
    chk_bit(taken, 1'b0);
    chk_bit(op_ready, 1'b1);
  endtask
  task automatic t_skip;
    set_flags(8'hA5);
    do_op(cbs_pkg::CBS_OP_SKIP_IO, 3'h5, 7'h00, 8'h20, 1'b0, 1'b1, 1);
    do_op(cbs_pkg::CBS_OP_SKIP_IO, 3'h7, 7'h00, 8'h80, 1'b1, 1'b1, 2);
    do_op(cbs_pkg::CBS_OP_SKIP_IO, 3'h4, 7'h00, 8'hEF, 1'b1, 1'b0, 0);
    do_op(cbs_pkg::CBS_OP_SKIP_IO, 3'h0, 7'h00, 8'h01, 1'b0, 1'b1, 1);
  endtask
  task automatic t_sbit;
    set_flags(8'h80);
    do_op(cbs_pkg::CBS_OP_BR_SET, 3'h7, 7'h7F, 8'h00, 1'b0, 1'b1, 1);
    do_op(cbs_pkg::CBS_OP_BR_SET, 3'h0, 7'h10, 8'h00, 1'b0, 1'b0, 0);
    do_op(cbs_pkg::CBS_OP_BR_CLR, 3'h7, 7'h10, 8'h00, 1'b0, 1'b0, 0);
    do_op(cbs_pkg::CBS_OP_BR_CLR, 3'h3, 7'h3F, 8'h00, 1'b0, 1'b1, 1);
  endtask
  task automatic t_zero;
    set_flags(8'h02);
    do_op(cbs_pkg::CBS_OP_BR_EQ, 3'h0, 7'h05, 8'h00, 1'b0, 1'b1, 1);
    do_op(cbs_pkg::CBS_OP_BR_NE, 3'h0, 7'h05, 8'h00, 1'b0, 1'b0, 0);
    set_flags(8'hFD);
    do_op(cbs_pkg::CBS_OP_BR_EQ, 3'h0, 7'h05, 8'h00, 1'b0, 1'b0, 0);
    do_op(cbs_pkg::CBS_OP_BR_NE, 3'h0, 7'h40, 8'h00, 1'b0, 1'b1, 1);
  endtask
  task automatic t_carry;
    for (int c = 0; c < 2; c++) begin
      set_flags(c[0] ? 8'h01 : 8'hFE);
      do_op(cbs_pkg::CBS_OP_BR_CS, 3'h0, 7'h02, 8'h00, 1'b0, c[0], c);
      do_op(cbs_pkg::CBS_OP_BR_LO, 3'h0, 7'h7D, 8'h00, 1'b0, c[0], c);
      do_op(cbs_pkg::CBS_OP_BR_CC, 3'h0, 7'h03, 8'h00, 1'b0, !c[0], 1 - c);
      do_op(cbs_pkg::CBS_OP_BR_SH, 3'h0, 7'h7C, 8'h00, 1'b0, !c[0], 1 - c);
    end
  endtask

  initial begin
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    t_reset();
    t_skip();
    t_sbit();
    t_zero();
    t_carry();
    conclude();
  end
endmodule
